// >>> verilog/adc_pkg.sv
// constants and types shared by both ends of the converter port
package adc_pkg;
	localparam int DATA_W = 8;
	localparam int RES_W = 10;
	localparam int CLK_NS = 25;
	localparam int POR_NS = 10000;
	localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
	localparam int REF_INT_NS = 500000;
	localparam int REF_INT_CYC = (REF_INT_NS + CLK_NS - 1) / CLK_NS;
	localparam int REF_EXT_NS = 50000;
	localparam int REF_EXT_CYC = (REF_EXT_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACQ_CLKS = 3;
	localparam int CONV_CLKS = 13;
	localparam int INT_CONV_NS = 3600;
	localparam int INT_TICK_CYC = (INT_CONV_NS + CONV_CLKS * CLK_NS - 1) / (CONV_CLKS * CLK_NS);
	localparam int PM_HI_BIT = 7;
	localparam int PM_LO_BIT = 6;
	localparam int ACQ_MODE_BIT = 5;
	localparam int UNIPOLAR_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'hc0;
	localparam logic [7:0] CTRL_STANDBY = 8'h40;
	localparam logic [7:0] BUS_IDLE = 8'hff;
	localparam int WR_PH = 3;
	localparam int RD_PH = 7;
	localparam int GAP_PH = 3;
	localparam int CLK_DIV = 3;
	typedef enum logic [1:0] {
		PM_SHUTDOWN = 2'b00,
		PM_STANDBY = 2'b01,
		PM_NORM_INT = 2'b10,
		PM_NORM_EXT = 2'b11
	} power_mode_t;
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_SHUTDOWN = 2'b10
	} pwr_state_t;
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_ACQ = 2'b01,
		CV_CONV = 2'b10
	} conv_state_t;
	typedef enum logic [3:0] {
		H_POR = 4'h0,
		H_IDLE = 4'h1,
		H_WRITE = 4'h2,
		H_WHOLD = 4'h3,
		H_WAIT = 4'h4,
		H_RDLO = 4'h5,
		H_RDGAP = 4'h6,
		H_RDHI = 4'h7
	} host_state_t;
endpackage : adc_pkg

// >>> verilog/adc_port_if.sv
// pin bundle between the host controller and the converter
`timescale 1ns/1ps
interface adc_port_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic high_byte_select;
	logic conv_clk;
	logic done_n;
	logic [adc_pkg::DATA_W-1:0] dev_d_out;
	logic dev_d_oe;
	logic [adc_pkg::DATA_W-1:0] host_d_out;
	logic host_d_oe;
	logic [adc_pkg::DATA_W-1:0] bus;
	// resolved bus level, pulled high when nobody drives
	assign bus = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : adc_pkg::BUS_IDLE);
	modport device (
		input cs_n, wr_n, rd_n, high_byte_select, conv_clk, bus,
		output done_n, dev_d_out, dev_d_oe
	);
	modport host (
		output cs_n, wr_n, rd_n, high_byte_select, conv_clk, host_d_out, host_d_oe,
		input done_n, bus
	);
endinterface : adc_port_if

// >>> verilog/adc_device.sv
// converter digital end: port, power modes, conversion sequence
`timescale 1ns/1ps
module adc_device (
	input wire logic core_clk,
	input wire logic rstn,
	adc_port_if.device port,
	input wire logic [adc_pkg::RES_W-1:0] sample_code,
	output logic conv_busy,
	output adc_pkg::pwr_state_t power_state,
	output logic ext_clk_mode,
	output logic [adc_pkg::DATA_W-1:0] ctrl_shadow
);
	localparam int SW = adc_pkg::DATA_W + 5;
	localparam int PAD_W = adc_pkg::DATA_W - 2;

	logic [SW-1:0] pin_vec;
	logic [SW-1:0] s1_reg;
	logic [SW-1:0] s2_reg;
	logic [2:0] prev_reg;
	logic cs_n_s;
	logic wr_n_s;
	logic rd_n_s;
	logic hbs_s;
	logic clk_s;
	logic [adc_pkg::DATA_W-1:0] bus_s;
	logic selected;
	logic wr_rise;
	logic rd_rise;
	logic clk_rise;
	logic start;
	logic step;
	logic conv_done;
	logic [adc_pkg::DATA_W-1:0] ctrl_reg;
	logic ext_reg;
	logic pend_pd_reg;
	logic pend_sb_reg;
	adc_pkg::conv_state_t conv_state_reg;
	adc_pkg::pwr_state_t pwr_reg;
	logic [4:0] step_reg;
	logic [3:0] tick_reg;
	logic [adc_pkg::RES_W-1:0] sample_reg;
	logic [adc_pkg::RES_W-1:0] result_reg;
	logic [adc_pkg::RES_W-1:0] coded;
	logic bipolar;
	logic done_reg;
	logic busy_reg;
	logic [adc_pkg::DATA_W-1:0] d_out_reg;
	logic d_oe_reg;

	// pin synchroniser
	assign pin_vec = {port.cs_n, port.wr_n, port.rd_n, port.high_byte_select,
		port.conv_clk, port.bus};

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s1_reg <= '1;
			s2_reg <= '1;
		end else begin
			s1_reg <= pin_vec;
			s2_reg <= s1_reg;
		end
	end

	assign cs_n_s = s2_reg[SW-1];
	assign wr_n_s = s2_reg[SW-2];
	assign rd_n_s = s2_reg[SW-3];
	assign hbs_s = s2_reg[SW-4];
	assign clk_s = s2_reg[SW-5];
	assign bus_s = s2_reg[adc_pkg::DATA_W-1:0];

	// edge history of write, read and clock
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			prev_reg <= 3'h7;
		end else begin
			prev_reg <= {wr_n_s, rd_n_s, clk_s};
		end
	end

	assign selected = !cs_n_s;
	assign wr_rise = selected && wr_n_s && !prev_reg[2];
	assign rd_rise = selected && rd_n_s && !prev_reg[1];
	assign clk_rise = selected && clk_s && !prev_reg[0];

	// a write while powered down only wakes the part
	assign start = wr_rise && (pwr_reg == adc_pkg::PWR_ACTIVE);
	assign step = ext_reg ? clk_rise : (tick_reg == 4'(adc_pkg::INT_TICK_CYC - 1));
	assign conv_done = !start && (conv_state_reg == adc_pkg::CV_CONV) && step &&
		(step_reg == 5'(adc_pkg::CONV_CLKS - 1));

	// control byte latch
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_reg <= adc_pkg::CTRL_RESET;
		end else if (start) begin
			ctrl_reg <= bus_s;
		end
	end

	// clock mode, untouched by power-down codes
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ext_reg <= 1'b1;
		end else if (start && bus_s[adc_pkg::PM_HI_BIT]) begin
			ext_reg <= bus_s[adc_pkg::PM_LO_BIT];
		end
	end

	// power-down request held until the conversion ends
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pend_pd_reg <= 1'b0;
			pend_sb_reg <= 1'b0;
		end else if (start) begin
			pend_pd_reg <= !bus_s[adc_pkg::PM_HI_BIT];
			pend_sb_reg <= bus_s[adc_pkg::PM_LO_BIT];
		end else if (conv_done) begin
			pend_pd_reg <= 1'b0;
		end
	end

	// internal conversion clock
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tick_reg <= 4'h0;
		end else if (ext_reg || conv_state_reg == adc_pkg::CV_IDLE || start) begin
			tick_reg <= 4'h0;
		end else if (tick_reg == 4'(adc_pkg::INT_TICK_CYC - 1)) begin
			tick_reg <= 4'h0;
		end else begin
			tick_reg <= tick_reg + 4'h1;
		end
	end

	// acquisition and conversion sequence
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			conv_state_reg <= adc_pkg::CV_IDLE;
			step_reg <= 5'h0;
		end else if (start) begin
			conv_state_reg <= adc_pkg::CV_ACQ;
			step_reg <= 5'h0;
		end else if (step) begin
			case (conv_state_reg)
				adc_pkg::CV_ACQ: begin
					if (step_reg == 5'(adc_pkg::ACQ_CLKS - 1)) begin
						conv_state_reg <= adc_pkg::CV_CONV;
						step_reg <= 5'h0;
					end else begin
						step_reg <= step_reg + 5'h1;
					end
				end
				adc_pkg::CV_CONV: begin
					if (step_reg == 5'(adc_pkg::CONV_CLKS - 1)) begin
						conv_state_reg <= adc_pkg::CV_IDLE;
						step_reg <= 5'h0;
					end else begin
						step_reg <= step_reg + 5'h1;
					end
				end
				adc_pkg::CV_IDLE: begin
					step_reg <= 5'h0;
				end
				default: begin
					conv_state_reg <= adc_pkg::CV_IDLE;
					step_reg <= 5'h0;
				end
			endcase
		end
	end

	// sample held at end of acquisition
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sample_reg <= '0;
		end else if (!start && step && conv_state_reg == adc_pkg::CV_ACQ &&
			step_reg == 5'(adc_pkg::ACQ_CLKS - 1)) begin
			sample_reg <= sample_code;
		end
	end

	// output coding
	assign bipolar = !ctrl_reg[adc_pkg::UNIPOLAR_BIT];
	assign coded = bipolar ? {~sample_reg[adc_pkg::RES_W-1], sample_reg[adc_pkg::RES_W-2:0]}
		: sample_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			result_reg <= '0;
		end else if (conv_done) begin
			result_reg <= coded;
		end
	end

	// power state
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pwr_reg <= adc_pkg::PWR_ACTIVE;
		end else begin
			case (pwr_reg)
				adc_pkg::PWR_ACTIVE: begin
					if (conv_done && pend_pd_reg) begin
						pwr_reg <= pend_sb_reg ? adc_pkg::PWR_STANDBY
							: adc_pkg::PWR_SHUTDOWN;
					end
				end
				adc_pkg::PWR_STANDBY: begin
					if (wr_rise) begin
						pwr_reg <= adc_pkg::PWR_ACTIVE;
					end
				end
				adc_pkg::PWR_SHUTDOWN: begin
					if (wr_rise) begin
						pwr_reg <= adc_pkg::PWR_ACTIVE;
					end
				end
				default: begin
					pwr_reg <= adc_pkg::PWR_ACTIVE;
				end
			endcase
		end
	end

	// conversion done flag, new result beats a read
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			done_reg <= 1'b1;
		end else if (conv_done) begin
			done_reg <= 1'b0;
		end else if (rd_rise) begin
			done_reg <= 1'b1;
		end
	end

	// data bus drive
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			d_oe_reg <= 1'b0;
			d_out_reg <= '0;
		end else begin
			d_oe_reg <= selected && !rd_n_s;
			if (hbs_s) begin
				d_out_reg <= {{PAD_W{bipolar & result_reg[adc_pkg::RES_W-1]}},
					result_reg[adc_pkg::RES_W-1:adc_pkg::DATA_W]};
			end else begin
				d_out_reg <= result_reg[adc_pkg::DATA_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= start || (conv_state_reg != adc_pkg::CV_IDLE && !conv_done);
		end
	end

	assign port.done_n = done_reg;
	assign port.dev_d_out = d_out_reg;
	assign port.dev_d_oe = d_oe_reg;
	assign conv_busy = busy_reg;
	assign power_state = pwr_reg;
	assign ext_clk_mode = ext_reg;
	assign ctrl_shadow = ctrl_reg;
endmodule : adc_device

// >>> verilog/adc_host.sv
// host controller end: strobes, conversion clock, read sequencing
`timescale 1ns/1ps
module adc_host #(
	parameter int REF_SETTLE_CYC = adc_pkg::REF_INT_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	adc_port_if.host port,
	input wire logic cmd_valid,
	input wire logic [adc_pkg::DATA_W-1:0] cmd_ctrl,
	input wire logic cmd_pipelined,
	input wire logic ext_ref,
	output logic cmd_ready,
	output logic result_valid,
	output logic [adc_pkg::RES_W-1:0] result_data,
	output logic accuracy_ok
);
	localparam int SW = adc_pkg::DATA_W + 1;

	logic [SW-1:0] s1_reg;
	logic [SW-1:0] s2_reg;
	logic done_s;
	logic done_p_reg;
	logic [adc_pkg::DATA_W-1:0] bus_s;
	adc_pkg::host_state_t state_reg;
	logic [2:0] ph_reg;
	logic [2:0] ph_lim;
	logic ph_end;
	logic [8:0] por_reg;
	logic [adc_pkg::DATA_W-1:0] ctrl_reg;
	logic pipe_reg;
	logic dummy_reg;
	logic wake_reg;
	logic pd_reg;
	logic shut_reg;
	logic [adc_pkg::DATA_W-1:0] lo_reg;
	logic [adc_pkg::RES_W-1:0] res_reg;
	logic valid_reg;
	logic ready_reg;
	logic settle_go;
	logic [15:0] settle_reg;
	logic ok_reg;
	logic outstanding_reg;
	logic cs_n_reg;
	logic wr_n_reg;
	logic rd_n_reg;
	logic hbs_reg;
	logic oe_reg;
	logic [adc_pkg::DATA_W-1:0] dout_reg;
	logic [1:0] div_reg;
	logic clk_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s1_reg <= '1;
			s2_reg <= '1;
			done_p_reg <= 1'b1;
		end else begin
			s1_reg <= {port.done_n, port.bus};
			s2_reg <= s1_reg;
			done_p_reg <= done_s;
		end
	end

	assign done_s = s2_reg[SW-1];
	assign bus_s = s2_reg[adc_pkg::DATA_W-1:0];

	always_comb begin
		case (state_reg)
			adc_pkg::H_WRITE: ph_lim = 3'(adc_pkg::WR_PH);
			adc_pkg::H_WHOLD: ph_lim = 3'(adc_pkg::WR_PH);
			adc_pkg::H_RDGAP: ph_lim = 3'(adc_pkg::GAP_PH);
			default: ph_lim = 3'(adc_pkg::RD_PH);
		endcase
	end

	assign ph_end = (ph_reg == ph_lim - 3'h1);
	assign settle_go = (state_reg == adc_pkg::H_POR && por_reg == 9'(adc_pkg::POR_CYC - 1)) ||
		(state_reg == adc_pkg::H_WRITE && ph_reg == 3'h0 && wake_reg && shut_reg);

	// sequencer
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= adc_pkg::H_POR;
			ph_reg <= 3'h0;
			por_reg <= 9'h0;
			ctrl_reg <= adc_pkg::CTRL_STANDBY;
			pipe_reg <= 1'b0;
			dummy_reg <= 1'b0;
			wake_reg <= 1'b0;
			pd_reg <= 1'b0;
			shut_reg <= 1'b0;
			lo_reg <= '0;
			res_reg <= '0;
			valid_reg <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			ph_reg <= ph_end ? 3'h0 : ph_reg + 3'h1;
			case (state_reg)
				adc_pkg::H_POR: begin
					ph_reg <= 3'h0;
					por_reg <= por_reg + 9'h1;
					if (por_reg == 9'(adc_pkg::POR_CYC - 1)) begin
						state_reg <= adc_pkg::H_WRITE;
						ctrl_reg <= adc_pkg::CTRL_STANDBY;
						dummy_reg <= 1'b1;
					end
				end
				adc_pkg::H_IDLE: begin
					ph_reg <= 3'h0;
					if (cmd_valid) begin
						ready_reg <= 1'b0;
						state_reg <= adc_pkg::H_WRITE;
						ctrl_reg <= cmd_ctrl;
						pipe_reg <= cmd_pipelined;
						dummy_reg <= 1'b0;
						wake_reg <= pd_reg;
					end
				end
				adc_pkg::H_WRITE: begin
					if (ph_end) begin
						state_reg <= adc_pkg::H_WHOLD;
					end
				end
				adc_pkg::H_WHOLD: begin
					if (ph_end) begin
						if (wake_reg) begin
							wake_reg <= 1'b0;
							pd_reg <= 1'b0;
							state_reg <= adc_pkg::H_WRITE;
						end else begin
							pd_reg <= !ctrl_reg[adc_pkg::PM_HI_BIT];
							shut_reg <= !ctrl_reg[adc_pkg::PM_HI_BIT] &&
								!ctrl_reg[adc_pkg::PM_LO_BIT];
							state_reg <= pipe_reg ? adc_pkg::H_RDLO : adc_pkg::H_WAIT;
						end
					end
				end
				adc_pkg::H_WAIT: begin
					ph_reg <= 3'h0;
					if (!done_s) begin
						state_reg <= adc_pkg::H_RDLO;
					end
				end
				adc_pkg::H_RDLO: begin
					if (ph_end) begin
						lo_reg <= bus_s;
						state_reg <= adc_pkg::H_RDGAP;
					end
				end
				adc_pkg::H_RDGAP: begin
					if (ph_end) begin
						state_reg <= adc_pkg::H_RDHI;
					end
				end
				adc_pkg::H_RDHI: begin
					if (ph_end) begin
						res_reg <= {bus_s[adc_pkg::RES_W-adc_pkg::DATA_W-1:0], lo_reg};
						valid_reg <= !dummy_reg;
						ready_reg <= 1'b1;
						state_reg <= adc_pkg::H_IDLE;
					end
				end
				default: begin
					state_reg <= adc_pkg::H_IDLE;
				end
			endcase
		end
	end

	// reference settling wait after power-up or shutdown exit
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			settle_reg <= 16'h0;
			ok_reg <= 1'b0;
		end else if (settle_go) begin
			settle_reg <= 16'h0;
			ok_reg <= 1'b0;
		end else if (!ok_reg) begin
			if (settle_reg == (ext_ref ? 16'(adc_pkg::REF_EXT_CYC - 1)
				: 16'(REF_SETTLE_CYC - 1))) begin
				ok_reg <= 1'b1;
			end else begin
				settle_reg <= settle_reg + 16'h1;
			end
		end
	end

	// conversion in flight keeps the port selected, set beats clear
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			outstanding_reg <= 1'b0;
		end else if (state_reg == adc_pkg::H_WHOLD && ph_end && !wake_reg) begin
			outstanding_reg <= 1'b1;
		end else if (done_p_reg && !done_s) begin
			outstanding_reg <= 1'b0;
		end
	end

	// pin drive
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cs_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			hbs_reg <= 1'b0;
			oe_reg <= 1'b0;
			dout_reg <= '0;
		end else begin
			cs_n_reg <= !((state_reg != adc_pkg::H_IDLE && state_reg != adc_pkg::H_POR) ||
				outstanding_reg);
			wr_n_reg <= state_reg != adc_pkg::H_WRITE;
			oe_reg <= state_reg == adc_pkg::H_WRITE || state_reg == adc_pkg::H_WHOLD;
			dout_reg <= ctrl_reg;
			rd_n_reg <= !(state_reg == adc_pkg::H_RDLO || state_reg == adc_pkg::H_RDHI);
			hbs_reg <= state_reg == adc_pkg::H_RDHI;
		end
	end

	// conversion clock divider
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			div_reg <= 2'h0;
			clk_reg <= 1'b0;
		end else if (div_reg == 2'(adc_pkg::CLK_DIV - 1)) begin
			div_reg <= 2'h0;
			clk_reg <= !clk_reg;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end

	assign port.cs_n = cs_n_reg;
	assign port.wr_n = wr_n_reg;
	assign port.rd_n = rd_n_reg;
	assign port.high_byte_select = hbs_reg;
	assign port.conv_clk = clk_reg;
	assign port.host_d_out = dout_reg;
	assign port.host_d_oe = oe_reg;
	assign cmd_ready = ready_reg;
	assign result_valid = valid_reg;
	assign result_data = res_reg;
	assign accuracy_ok = ok_reg;
endmodule : adc_host

// >>> test/adc_port_checker.sv
// pin-level checks on the link between host and converter
`timescale 1ns/1ps
module adc_port_checker (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic high_byte_select,
	input wire logic conv_clk,
	input wire logic done_n,
	input wire logic [adc_pkg::DATA_W-1:0] dev_d_out,
	input wire logic dev_d_oe,
	input wire logic host_d_oe,
	input wire logic [adc_pkg::DATA_W-1:0] bus
);
	logic cc_q;
	logic wr_q;
	logic wr_seen;
	logic [7:0] cc_cnt;
	logic [9:0] por_cnt;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cc_q <= 1'b0;
			wr_q <= 1'b1;
			wr_seen <= 1'b0;
		end else begin
			cc_q <= conv_clk;
			wr_q <= wr_n;
			if (wr_n && !wr_q) begin
				wr_seen <= 1'b1;
			end
		end
	end
	// conversion clock rises since the last write release
	always_ff @(posedge core_clk) begin
		if (!rstn || (wr_n && !wr_q)) begin
			cc_cnt <= 8'h00;
		end else if (conv_clk && !cc_q && cc_cnt != 8'hff) begin
			cc_cnt <= cc_cnt + 8'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			por_cnt <= 10'h000;
		end else if (por_cnt != 10'h3ff) begin
			por_cnt <= por_cnt + 10'h001;
		end
	end
	a_upper_byte_fill: assert property ((dev_d_oe && high_byte_select) [*4] |->
		(dev_d_out[7:2] == 6'h00) || (dev_d_out[7:2] == {6{dev_d_out[1]}}))
		else $error("upper byte fill wrong");
	a_reset_outputs: assert property ($rose(rstn) |-> done_n && !dev_d_oe && cs_n)
		else $error("outputs wrong after reset");
	a_por_write_quiet: assert property (!wr_n |-> por_cnt >= adc_pkg::POR_CYC)
		else $error("write during reset interval");
	a_first_write_standby: assert property ($rose(wr_n) && !wr_seen |->
		host_d_oe && bus == adc_pkg::CTRL_STANDBY)
		else $error("first write is not a standby byte");
	a_conv_step_count: assert property ($fell(done_n) |->
		(cc_cnt >= 8'h0f && cc_cnt <= 8'h10) || (cc_cnt >= 8'h1f && cc_cnt <= 8'h22))
		else $error("conversion step count wrong");
	a_release_deselected: assert property (cs_n [*4] |-> !dev_d_oe)
		else $error("bus driven while deselected");
	a_drive_only_reading: assert property (dev_d_oe |->
		!($past(rd_n, 2) && $past(rd_n, 3) && $past(rd_n, 4)))
		else $error("bus driven without read");
	a_done_holds: assert property ((!done_n && rd_n) [*4] |=> !done_n)
		else $error("done released without read");
	a_done_clears_read: assert property ($rose(done_n) |->
		!($past(rd_n, 3) && $past(rd_n, 4) && $past(rd_n, 5) && $past(rd_n, 6)))
		else $error("done released with no read");
	c_result_ready: cover property ($fell(done_n));
	c_upper_read: cover property (dev_d_oe && high_byte_select);
	c_later_write: cover property ($rose(wr_n) && wr_seen);
endmodule : adc_port_checker

// >>> test/adc_parallel_readout_power_control_bench.sv
// self-checking bench joining host and converter ends
`timescale 1ns/1ps
module adc_parallel_readout_power_control_bench;
	logic core_clk;
	logic rstn;
	logic cmd_valid;
	logic [7:0] cmd_ctrl;
	logic cmd_pipelined;
	logic ext_ref;
	logic cmd_ready;
	logic result_valid;
	logic [9:0] result_data;
	logic accuracy_ok;
	logic [9:0] sample_code;
	logic conv_busy;
	adc_pkg::pwr_state_t power_state;
	logic ext_clk_mode;
	logic [7:0] ctrl_shadow;
	logic [7:0] hi_seen;
	logic busy_pd;
	int failures;
	int n_tests;
	adc_port_if port ();
	adc_host #(.REF_SETTLE_CYC(200)) adc_host_i (.core_clk(core_clk), .rstn(rstn),
		.port(port.host), .cmd_valid(cmd_valid), .cmd_ctrl(cmd_ctrl),
		.cmd_pipelined(cmd_pipelined), .ext_ref(ext_ref), .cmd_ready(cmd_ready),
		.result_valid(result_valid), .result_data(result_data), .accuracy_ok(accuracy_ok));
	adc_device adc_device_i (.core_clk(core_clk), .rstn(rstn), .port(port.device),
		.sample_code(sample_code), .conv_busy(conv_busy), .power_state(power_state),
		.ext_clk_mode(ext_clk_mode), .ctrl_shadow(ctrl_shadow));
	adc_port_checker adc_port_checker_i (.core_clk(core_clk), .rstn(rstn), .cs_n(port.cs_n),
		.wr_n(port.wr_n), .rd_n(port.rd_n), .high_byte_select(port.high_byte_select),
		.conv_clk(port.conv_clk), .done_n(port.done_n), .dev_d_out(port.dev_d_out),
		.dev_d_oe(port.dev_d_oe), .host_d_oe(port.host_d_oe), .bus(port.bus));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : tick
	function automatic logic pick(input int which);
		return (which == 0) ? cmd_ready : ((which == 1) ? result_valid : accuracy_ok);
	endfunction : pick
	task automatic wait_for(input int which);
		int n;
		n = 0;
		while (pick(which) !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		if (pick(which) !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t wait limit reached", $time);
		end
	endtask : wait_for
	task automatic run_cmd(input logic [7:0] ctrl, input logic pipe, input logic [9:0] smp,
		input logic [9:0] exp, input logic uni);
		logic [7:0] hi;
		hi = {(uni ? 6'h00 : {6{exp[9]}}), exp[9:8]};
		sample_code = smp;
		wait_for(0);
		cmd_ctrl = ctrl;
		cmd_pipelined = pipe;
		cmd_valid = 1'b1;
		tick(1);
		cmd_valid = 1'b0;
		wait_for(1);
		check(result_data, exp, "result");
		check(hi_seen, hi, "upper byte");
	endtask : run_cmd
	// no conversion may run for two cycles while powered down
	always @(posedge core_clk) begin
		if (busy_pd && conv_busy === 1'b1 && power_state !== adc_pkg::PWR_ACTIVE) begin
			failures++;
			$display("[FAIL] %0t conversion while powered down", $time);
		end
		busy_pd <= conv_busy === 1'b1 && power_state !== adc_pkg::PWR_ACTIVE;
		if (port.dev_d_oe === 1'b1 && port.high_byte_select === 1'b1) begin
			hi_seen <= port.bus;
		end
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_ctrl = 8'h00;
		cmd_pipelined = 1'b0;
		ext_ref = 1'b0;
		sample_code = 10'h000;
		hi_seen = 8'h00;
		busy_pd = 1'b0;
		failures = 0;
		n_tests = 0;
		repeat (8) @(posedge core_clk);
		#2;
		rstn = 1'b1;
		tick(1);
		check(port.done_n, 1'b1, "done after reset");
		check(ext_clk_mode, 1'b1, "clock mode after reset");
		check(ctrl_shadow, adc_pkg::CTRL_RESET, "control after reset");
		check(port.dev_d_oe, 1'b0, "bus after reset");
		wait_for(0);
		check(power_state, adc_pkg::PWR_STANDBY, "standby after dummy");
		check(ctrl_shadow, adc_pkg::CTRL_STANDBY, "standby byte");
		check(accuracy_ok, 1'b0, "settle after power-up");
		run_cmd(8'hff, 1'b0, 10'h3a5, 10'h3a5, 1'b1);
		check(power_state, adc_pkg::PWR_ACTIVE, "awake from standby");
		check(accuracy_ok, 1'b1, "settled after power-up");
		run_cmd(8'hc0, 1'b0, 10'h15a, 10'h35a, 1'b0);
		run_cmd(8'h88, 1'b0, 10'h001, 10'h001, 1'b1);
		check(ext_clk_mode, 1'b0, "internal clock mode");
		run_cmd(8'h08, 1'b0, 10'h2f0, 10'h2f0, 1'b1);
		check(power_state, adc_pkg::PWR_SHUTDOWN, "shutdown after conversion");
		check(ext_clk_mode, 1'b0, "clock mode kept in shutdown");
		tick(50);
		check(conv_busy, 1'b0, "idle in shutdown");
		run_cmd(8'hc8, 1'b0, 10'h0f0, 10'h0f0, 1'b1);
		check(power_state, adc_pkg::PWR_ACTIVE, "awake from shutdown");
		check(ext_clk_mode, 1'b1, "external clock mode");
		check(accuracy_ok, 1'b0, "settle after shutdown");
		wait_for(2);
		check(accuracy_ok, 1'b1, "settled after shutdown");
		run_cmd(8'hc8, 1'b1, 10'h2aa, 10'h0f0, 1'b1);
		run_cmd(8'hc8, 1'b0, 10'h2aa, 10'h2aa, 1'b1);
		run_cmd(8'h08, 1'b0, 10'h155, 10'h155, 1'b1);
		check(power_state, adc_pkg::PWR_SHUTDOWN, "shutdown in external mode");
		ext_ref = 1'b1;
		run_cmd(8'hc8, 1'b0, 10'h0c3, 10'h0c3, 1'b1);
		tick(300);
		check(accuracy_ok, 1'b0, "external reference settle pending");
		wait_for(2);
		check(accuracy_ok, 1'b1, "settled with external reference");
		close_out();
	end
endmodule : adc_parallel_readout_power_control_bench
